// *** rtl/eabc_regs.vh ***
// Constants for the external area bus control block
`ifndef EABC_REGS_VH
`define EABC_REGS_VH
`define EABC_ADDR_W        24
`define EABC_AREA_MSB      23
`define EABC_AREA_LSB      21
`define EABC_AREAS         8
`define EABC_IF_BASIC      2'h0
`define EABC_IF_DRAM       2'h1
`define EABC_IF_SDRAM      2'h2
`define EABC_IF_BROM       2'h3
`define EABC_RST_WAITS     3'h7
`define EABC_RST_AST       8'hff
`define EABC_RST_RDN       8'h00
`define EABC_RST_CSX       16'h0000
`define EABC_INT_STATES    4'h1
`define EABC_ST_IDLE       3'h0
`define EABC_ST_LEAD       3'h1
`define EABC_ST_T1         3'h2
`define EABC_ST_T2         3'h3
`define EABC_ST_TW         3'h4
`define EABC_ST_T3         3'h5
`define EABC_ST_TRAIL      3'h6
`endif

// *** rtl/eabc_sync.v ***
// Three-stage input synchroniser with agreement filter
module eabc_sync (
  input  wire clock_i,
  input  wire nrst_i,
  input  wire d_i,
  output reg  q_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1  <= 1'b1;
      s2  <= 1'b1;
      s3  <= 1'b1;
      q_o <= 1'b1;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      // Change counts once stages two and three agree
      if (s2 == s3)
        q_o <= s3;
    end
  end
endmodule

// *** rtl/eabc_area_dec.v ***
// Area decode and internal/external classification
`include "eabc_regs.vh"
module eabc_area_dec (
  input  wire [23:0] addr_i,
  input  wire        rom_en_i,
  input  wire [23:0] rom_size_i,
  input  wire        internal_ram_enable_i,
  input  wire [23:0] ram_base_i,
  input  wire [23:0] io_base_i,
  output wire [2:0]  area_o,
  output wire        internal_o
);
  wire in_rom;
  wire in_ram;
  wire in_io;
  // 2-Mbyte areas from the top three address bits [RULE_01]
  assign area_o = addr_i[`EABC_AREA_MSB:`EABC_AREA_LSB];
  assign in_rom = (area_o == 3'h0) && rom_en_i && (addr_i < rom_size_i); // [RULE_20]
  assign in_ram = (area_o == 3'h7) && internal_ram_enable_i && (addr_i >= ram_base_i) && (addr_i < io_base_i); // [RULE_19]
  assign in_io  = (area_o == 3'h7) && (addr_i >= io_base_i); // [RULE_19]
  assign internal_o = in_rom | in_ram | in_io;
endmodule

// *** rtl/eabc_top.v ***
// External area bus control: per-area cycle sequencing and chip selects
// Operation
// (RULE_01) Address space splits into eight 2-Mbyte areas, each configured separately.
// (RULE_02) One active-low chip select per area, low during its external access.
// (RULE_03) Each area is an 8-bit or 16-bit access space.
// (RULE_04) Width bit 0 means 16-bit; state bit 0 means 2 states, no waits.
// (RULE_05) Bus is 8-bit mode only when all areas are 8-bit.
// (RULE_06) Each area runs two or three access states per cycle.
// (RULE_07) Two-state areas insert neither program nor pin waits.
// (RULE_08) Three-state areas insert 0 to 7 program waits, plus pin waits.
// (RULE_09) DRAM, SDRAM and burst ROM areas may ignore the state setting.
// (RULE_10) On-chip memory and I/O use fixed width and state count.
// (RULE_11) Read strobe negates at cycle end or a half-state earlier; code negates at cycle end, early case only flagged.
// (RULE_12) Optional extension states before/after assert only select, strobe and address.
// (RULE_13) Interface type is chosen per area.
// (RULE_14) Areas 0 and 1 accept basic or burst ROM only.
// (RULE_15) Areas 2-5 accept basic, DRAM or SDRAM; DRAM uses selects as row strobes.
// (RULE_16) Continuous DRAM uses area-2 select alone as row strobe.
// (RULE_17) Continuous SDRAM uses selects 2-5 as RAS, CAS, WE, CLK; OE as CKE.
// (RULE_18) Areas 6 and 7 are basic interface only.
// (RULE_19) Area 7 holds internal RAM and I/O; RAM disabled means external.
// (RULE_20) ROM enabled maps ROM range of area 0 internally, rest external.
// (RULE_21) Reset gives basic interface, three states, width from operating mode.
// (RULE_22) Select pins drive only when direction bit is 1; area 0 reset rule.
// (RULE_23) With pin waits on, a low hold input at falling edge adds waits.
// (RULE_24) Reset gives seven program waits and hold input disabled.
`include "eabc_regs.vh"
module eabc_top #(
  parameter ADDR_W = 24
) (
  input  wire              clock_i,
  input  wire              nrst_i,
  input  wire              mode_width8_i,
  input  wire              rom_en_i,
  input  wire [23:0]       rom_size_i,
  input  wire [23:0]       ram_base_i,
  input  wire [23:0]       io_base_i,
  input  wire              cfg_we_i,
  input  wire [7:0]        area_width_control_i,
  input  wire [7:0]        area_state_count_control_i,
  input  wire [23:0]       program_wait_field_i,
  input  wire [7:0]        read_negation_control_i,
  input  wire [15:0]       select_extension_control_i,
  input  wire [15:0]       area_if_type_i,
  input  wire              dram_continuous_i,
  input  wire              pin_wait_enable_i,
  input  wire              internal_ram_enable_i,
  input  wire [7:0]        select_dir_i,
  input  wire              select_dir_we_i,
  input  wire              req_i,
  input  wire              req_write_i,
  input  wire [ADDR_W-1:0] req_addr_i,
  input  wire              wait_n_i,
  input  wire              sdram_ras_n_i,
  input  wire              sdram_cas_n_i,
  input  wire              sdram_we_n_i,
  input  wire              sdram_clk_i,
  input  wire              sdram_cke_i,
  input  wire [3:0]        dram_ras_n_i,
  output reg               busy_o,
  output reg               done_o,
  output reg               bus16_mode_o,
  output reg  [7:0]        area_chip_select_n_o,
  output reg  [7:0]        area_chip_select_oe_n_o,
  output reg               address_strobe_n_o,
  output reg               read_strobe_n_o,
  output reg               read_early_o,
  output reg               write_strobe_n_o,
  output reg               area_is_16bit_o,
  output reg               oe_as_cke_o,
  output reg               cke_o,
  output reg  [ADDR_W-1:0] addr_o
);
  reg [7:0]  width8;
  reg [7:0]  three_st;
  reg [23:0] waits;
  reg [7:0]  rdn;
  reg [15:0] csx;
  reg [15:0] iftype;
  reg [7:0]  dir;
  reg        dir_loaded;
  reg        pin_wait_en;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [2:0]  area;
  reg        write_cyc;
  reg [2:0]  wait_cnt;
  reg        cs_active;
  reg [15:0] legal_if;
  reg        wait_fall;
  wire [2:0] dec_area;
  wire       dec_internal;
  wire       wait_n_sync;
  wire [1:0] cur_if;
  wire       cur_3st;
  wire       w_now;
  integer    i;
  integer    j;

  eabc_area_dec u_dec (
    .addr_i                (req_addr_i[23:0]),
    .rom_en_i              (rom_en_i),
    .rom_size_i            (rom_size_i),
    .internal_ram_enable_i (internal_ram_enable_i),
    .ram_base_i            (ram_base_i),
    .io_base_i             (io_base_i),
    .area_o                (dec_area),
    .internal_o            (dec_internal)
  );

  // Hold input comes from a pin, so it passes the synchroniser
  eabc_sync u_wait (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     (wait_n_i),
    .q_o     (wait_n_sync)
  );

  assign cur_if  = iftype[area*2 +: 2];
  // Non-basic interfaces run their own state count [RULE_09]
  assign cur_3st = three_st[area] && (cur_if == `EABC_IF_BASIC);
  // Direction of the cycle being started; the stored copy lags one edge behind while still in IDLE
  assign w_now   = (state == `EABC_ST_IDLE) ? req_write_i : write_cyc;

  // Per-area legality of interface type [RULE_14] [RULE_15] [RULE_18]
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      case (area_if_type_i[i*2 +: 2])
        `EABC_IF_BASIC: legal_if[i*2 +: 2] = `EABC_IF_BASIC;
        `EABC_IF_BROM:  legal_if[i*2 +: 2] = (i < 2) ? `EABC_IF_BROM : `EABC_IF_BASIC;
        `EABC_IF_DRAM:  legal_if[i*2 +: 2] = (i >= 2 && i <= 5) ? `EABC_IF_DRAM : `EABC_IF_BASIC;
        default:        legal_if[i*2 +: 2] = (i >= 2 && i <= 5) ? `EABC_IF_SDRAM : `EABC_IF_BASIC;
      endcase
    end
  end

  // Configuration store; reset defaults from mode straps are caught after release
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      width8      <= 8'h00;
      three_st    <= `EABC_RST_AST;                                   // [RULE_21]
      waits       <= {8{`EABC_RST_WAITS}};                            // [RULE_24]
      rdn         <= `EABC_RST_RDN;
      csx         <= `EABC_RST_CSX;
      iftype      <= 16'h0000;                                        // [RULE_21]
      pin_wait_en <= 1'b0;                                            // [RULE_24]
      dir         <= 8'h00;
      dir_loaded  <= 1'b0;
    end else begin
      if (!dir_loaded) begin
        dir_loaded <= 1'b1;
        width8     <= {8{mode_width8_i}};                             // [RULE_21]
        dir        <= {7'h00, ~rom_en_i};                             // [RULE_22]
      end else begin
        if (cfg_we_i && state == `EABC_ST_IDLE) begin
          width8      <= area_width_control_i;                        // [RULE_03] [RULE_04]
          three_st    <= area_state_count_control_i;                  // [RULE_04] [RULE_06]
          waits       <= program_wait_field_i;                        // [RULE_08]
          rdn         <= read_negation_control_i;                     // [RULE_11]
          csx         <= select_extension_control_i;                  // [RULE_12]
          iftype      <= legal_if;                                    // [RULE_13]
          pin_wait_en <= pin_wait_enable_i;
        end
        if (select_dir_we_i)
          dir <= select_dir_i;
      end
    end
  end

  // Hold input sampled on the falling edge, as the external part sees it
  always @(negedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      wait_fall <= 1'b1;
    else
      wait_fall <= wait_n_sync;
  end

  always @* begin
    next_state = state;
    case (state)
      `EABC_ST_IDLE:
        if (req_i && !dec_internal && dir_loaded)                    // [RULE_10]
          next_state = csx[8 + dec_area] ? `EABC_ST_LEAD : `EABC_ST_T1;
      `EABC_ST_LEAD:
        next_state = `EABC_ST_T1;
      `EABC_ST_T1:
        next_state = `EABC_ST_T2;
      `EABC_ST_T2:
        if (!cur_3st)                                                 // [RULE_07]
          next_state = csx[area] ? `EABC_ST_TRAIL : `EABC_ST_IDLE;
        else if (waits[area*3 +: 3] != 3'h0 || (pin_wait_en && !wait_fall))
          next_state = `EABC_ST_TW;                                   // [RULE_08] [RULE_23]
        else
          next_state = `EABC_ST_T3;
      `EABC_ST_TW:
        if (wait_cnt == 3'h0 && !(pin_wait_en && !wait_fall))         // [RULE_23]
          next_state = `EABC_ST_T3;
      `EABC_ST_T3:
        next_state = csx[area] ? `EABC_ST_TRAIL : `EABC_ST_IDLE;      // [RULE_12]
      `EABC_ST_TRAIL:
        next_state = `EABC_ST_IDLE;
      default:
        next_state = `EABC_ST_IDLE;
    endcase
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state                   <= `EABC_ST_IDLE;
      area                    <= 3'h0;
      write_cyc               <= 1'b0;
      wait_cnt                <= 3'h0;
      cs_active               <= 1'b0;
      busy_o                  <= 1'b0;
      done_o                  <= 1'b0;
      bus16_mode_o            <= 1'b1;
      area_chip_select_n_o    <= 8'hff;
      area_chip_select_oe_n_o <= 8'hff;
      address_strobe_n_o      <= 1'b1;
      read_strobe_n_o         <= 1'b1;
      read_early_o            <= 1'b0;
      write_strobe_n_o        <= 1'b1;
      area_is_16bit_o         <= 1'b0;
      oe_as_cke_o             <= 1'b0;
      cke_o                   <= 1'b0;
      addr_o                  <= {ADDR_W{1'b0}};
    end else begin
      state  <= next_state;
      done_o <= 1'b0;
      if (state == `EABC_ST_IDLE && next_state != `EABC_ST_IDLE) begin
        area      <= dec_area;
        write_cyc <= req_write_i;
        addr_o    <= req_addr_i;
      end
      if (state == `EABC_ST_T2)
        wait_cnt <= (waits[area*3 +: 3] == 3'h0) ? 3'h0 : waits[area*3 +: 3] - 3'h1;
      else if (state == `EABC_ST_TW && wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      if ((state == `EABC_ST_T3 || (state == `EABC_ST_T2 && !cur_3st)) && next_state != `EABC_ST_TRAIL)
        done_o <= 1'b1;
      else if (state == `EABC_ST_TRAIL)
        done_o <= 1'b1;
      cs_active          <= (next_state != `EABC_ST_IDLE);
      busy_o             <= (next_state != `EABC_ST_IDLE);
      bus16_mode_o       <= ~&width8;                                 // [RULE_05]
      area_is_16bit_o    <= ~width8[(next_state == `EABC_ST_IDLE) ? dec_area : area];
      address_strobe_n_o <= (next_state == `EABC_ST_IDLE);            // [RULE_12]
      read_strobe_n_o    <= !(!w_now && (next_state == `EABC_ST_T1 || next_state == `EABC_ST_T2 ||
                              next_state == `EABC_ST_TW || next_state == `EABC_ST_T3));
      // Early negation is flagged; the half-state shaping needs the opposite clock edge
      read_early_o       <= rdn[(state == `EABC_ST_IDLE) ? dec_area : area] && !w_now; // [RULE_11]
      write_strobe_n_o   <= !(write_cyc && (next_state == `EABC_ST_T2 || next_state == `EABC_ST_TW ||
                              next_state == `EABC_ST_T3));
      oe_as_cke_o        <= (iftype[5:4] == `EABC_IF_SDRAM);          // [RULE_17]
      cke_o              <= sdram_cke_i;                              // [RULE_17]
      for (j = 0; j < 8; j = j + 1) begin
        area_chip_select_oe_n_o[j] <= ~dir[j];                        // [RULE_22]
        if (j >= 2 && j <= 5 && iftype[5:4] == `EABC_IF_SDRAM)
          area_chip_select_n_o[j] <= (j == 2) ? sdram_ras_n_i : (j == 3) ? sdram_cas_n_i :
                                     (j == 4) ? sdram_we_n_i : sdram_clk_i; // [RULE_17]
        else if (j >= 2 && j <= 5 && iftype[j*2 +: 2] == `EABC_IF_DRAM)
          area_chip_select_n_o[j] <= dram_continuous_i ? ((j == 2) ? &dram_ras_n_i : 1'b1)
                                                       : dram_ras_n_i[j-2]; // [RULE_15] [RULE_16]
        else
          area_chip_select_n_o[j] <= !(next_state != `EABC_ST_IDLE &&
                                       ((next_state != `EABC_ST_IDLE && state == `EABC_ST_IDLE) ?
                                        dec_area == j : area == j)); // [RULE_02]
      end
    end
  end
endmodule

// *** verif/eabc_top_asserts.sv ***
// Port-level checker of the bus controller's select, strobe and handshake relations
module eabc_top_asserts #(
  parameter ADDR_W = 24
) (
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire logic [7:0]        area_chip_select_n_o,
  input wire logic              address_strobe_n_o,
  input wire logic              read_strobe_n_o,
  input wire logic              write_strobe_n_o,
  input wire logic              oe_as_cke_o,
  input wire logic [ADDR_W-1:0] addr_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  reset_idle_a: assert property ($rose(nrst_i) |-> area_chip_select_n_o == 8'hff && !busy_o)
    else $error("bus not idle after reset");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  done_idle_a: assert property (done_o |-> area_chip_select_n_o == 8'hff && address_strobe_n_o)
    else $error("select still low at done");
  one_select_a: assert property (!oe_as_cke_o |-> $onehot0(~area_chip_select_n_o))
    else $error("several selects low");
  select_area_a: assert property (area_chip_select_n_o != 8'hff && !oe_as_cke_o
    |-> !area_chip_select_n_o[addr_o[ADDR_W-1 -: 3]])
    else $error("select does not match address area");
  strobe_cs_a: assert property (!(read_strobe_n_o && write_strobe_n_o) |-> area_chip_select_n_o != 8'hff)
    else $error("strobe outside selected cycle");
  strobe_excl_a: assert property (!read_strobe_n_o |-> write_strobe_n_o)
    else $error("read and write strobes together");
  as_busy_a: assert property (!address_strobe_n_o |-> busy_o)
    else $error("address strobe while idle");
endmodule
bind eabc_top eabc_top_asserts #(.ADDR_W(ADDR_W)) i_eabc_top_asserts (.clock_i, .nrst_i, .busy_o, .done_o,
  .area_chip_select_n_o, .address_strobe_n_o, .read_strobe_n_o, .write_strobe_n_o, .oe_as_cke_o, .addr_o);

// *** verif/eabc_ext_dev.sv ***
// Far-side memory device that can stretch an access through the hold line
module eabc_ext_dev (
  input  wire logic       clock_i,
  input  wire logic [7:0] cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [3:0] hold_i,
  output logic            wait_n_o = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt  = 0;
  logic seen = 0;
  // Line is pulled up, so it rests high whenever no hold is requested
  always @(posedge clock_i) begin
    #1;
    if (cs_n_i == 8'hff) begin
      seen = 0;
      cnt = 0;
    end else if (!seen && !(rd_n_i && wr_n_i)) begin
      seen = 1;
      cnt = hold_i;
    end
    wait_n_o = (cnt == 0);
    if (cnt > 0) cnt--;
  end
endmodule

// *** verif/external_area_bus_control_test.sv ***
// Self-checking bench for the external area bus controller
module external_area_bus_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0, nrst_i = 0, mode_width8_i = 1, cfg_we_i = 0, pin_wait_enable_i = 0;
  logic internal_ram_enable_i = 1, select_dir_we_i = 0, req_i = 0, req_write_i = 0, rom_en_i = 0;
  logic [7:0]  area_width_control_i = 8'hff, area_state_count_control_i = 8'hff, read_negation_control_i = 0;
  logic [7:0]  select_dir_i = 0, area_chip_select_n_o, area_chip_select_oe_n_o;
  logic [23:0] program_wait_field_i = 24'hff_ffff, req_addr_i = 0, ram_base_i = 24'hff_c000, addr_o;
  logic [15:0] select_extension_control_i = 0, area_if_type_i = 0;
  logic        read_early_o, area_is_16bit_o, oe_as_cke_o, cke_o;
  logic [8:0]  junk = 0;
  logic [3:0]  hold = 0;
  logic [2:0]  ar;
  logic        busy_o, done_o, bus16_mode_o, address_strobe_n_o, read_strobe_n_o, write_strobe_n_o, wait_n_i;
  int          n_fail = 0, checked = 0, n;
  eabc_top i_eabc_top (.clock_i, .nrst_i, .mode_width8_i, .rom_en_i, .rom_size_i(24'h04_0000),
    .ram_base_i, .io_base_i(24'hff_ff00), .cfg_we_i, .area_width_control_i, .area_state_count_control_i,
    .program_wait_field_i, .read_negation_control_i, .select_extension_control_i, .area_if_type_i,
    .dram_continuous_i(1'b0), .pin_wait_enable_i, .internal_ram_enable_i, .select_dir_i, .select_dir_we_i,
    .req_i, .req_write_i, .req_addr_i, .wait_n_i, .sdram_ras_n_i(junk[0]), .sdram_cas_n_i(junk[1]),
    .sdram_we_n_i(junk[2]), .sdram_clk_i(junk[3]), .sdram_cke_i(junk[4]), .dram_ras_n_i(junk[8:5]),
    .busy_o, .done_o, .bus16_mode_o, .area_chip_select_n_o, .area_chip_select_oe_n_o, .address_strobe_n_o,
    .read_strobe_n_o, .read_early_o, .write_strobe_n_o, .area_is_16bit_o, .oe_as_cke_o, .cke_o, .addr_o);
  eabc_ext_dev i_eabc_ext_dev (.clock_i, .cs_n_i(area_chip_select_n_o), .rd_n_i(read_strobe_n_o),
    .wr_n_i(write_strobe_n_o), .hold_i(hold), .wait_n_o(wait_n_i));
  initial forever #2 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cfg();
    cfg_we_i = 1;
    @(posedge clock_i);
    #1 cfg_we_i = 0;
  endtask
  // Select-low cycles in ncs, read-strobe-low cycles checked against exp_st when not negative
  task automatic acc(input logic [23:0] a, input logic w, input int exp_st, output int ncs);
    int nst, k;
    ncs = 0;
    nst = 0;
    @(posedge clock_i);
    #1 req_addr_i = a;
    req_write_i = w;
    req_i = 1;
    junk = 9'($urandom);
    for (k = 0; k < 40 && !done_o; k++) begin
      @(posedge clock_i);
      #1 if (area_chip_select_n_o !== 8'hff) ncs++;
      if (read_strobe_n_o === 1'b0) nst++;
    end
    req_i = 0;
    if (exp_st >= 0) chk(nst, exp_st);
  endtask
  function automatic int states(input int a);
    return area_state_count_control_i[a] ? 3 + program_wait_field_i[3*a +: 3] : 2;
  endfunction
  initial begin
    void'($urandom(32'h507d));
    repeat (16) @(posedge clock_i);
    #1 nrst_i = 1;
    repeat (2) @(posedge clock_i);
    #1 chk(bus16_mode_o, 0);
    chk(area_chip_select_oe_n_o, 8'hfe);
    acc(24'h20_0010, 0, 10, n);
    chk(n, 10);
    select_dir_i = 8'hff;
    select_dir_we_i = 1;
    @(posedge clock_i);
    #1 select_dir_we_i = 0;
    @(posedge clock_i);
    #1 chk(area_chip_select_oe_n_o, 8'h00);
    $display("test reset defaults done");
    for (int i = 0; i < 16; i++) begin
      area_width_control_i = (i == 0) ? 8'hff : 8'($urandom);
      area_state_count_control_i = (i == 1) ? 8'h00 : 8'($urandom);
      program_wait_field_i = 24'($urandom);
      read_negation_control_i = 8'($urandom);
      select_extension_control_i = 16'($urandom);
      cfg();
      ar = 3'($urandom_range(0, 6));
      req_write_i = 1'($urandom);
      acc({ar, 21'($urandom)}, req_write_i, req_write_i ? -1 : states(ar), n);
      chk(n, states(ar) + select_extension_control_i[8 + ar] + select_extension_control_i[ar]);
      chk(bus16_mode_o, area_width_control_i != 8'hff);
      chk(area_is_16bit_o, !area_width_control_i[ar]);
      chk(read_early_o, read_negation_control_i[ar] && !req_write_i);
    end
    $display("test random areas done");
    select_extension_control_i = 0;
    // Four program waits in area 2 give the synchronised hold line time to arrive
    program_wait_field_i = 24'h00_0100;
    area_state_count_control_i = 8'hff;
    pin_wait_enable_i = 1;
    hold = 4'h6;
    cfg();
    acc(24'h40_0000, 0, -1, n);
    chk(n > 7, 1);
    area_state_count_control_i = 8'h00;
    cfg();
    acc(24'h40_0000, 0, 2, n);
    chk(n, 2);
    $display("test pin waits done");
    acc(ram_base_i, 0, 0, n);
    chk(done_o, 0);
    chk(n, 0);
    internal_ram_enable_i = 0;
    cfg();
    acc(ram_base_i, 0, 2, n);
    chk(n, 2);
    $display("test internal ram done");
    area_if_type_i = 16'h0020;
    junk = 9'($urandom);
    cfg();
    @(posedge clock_i);
    #1 chk(oe_as_cke_o, 1);
    chk(area_chip_select_n_o[5:2], junk[3:0]);
    chk(cke_o, junk[4]);
    area_if_type_i = 16'h0000;
    cfg();
    @(posedge clock_i);
    #1 chk(oe_as_cke_o, 0);
    $display("test memory interface done");
    rom_en_i = 1;
    acc(24'h00_0100, 0, 0, n);
    chk(n, 0);
    acc(24'h08_0000, 0, 2, n);
    chk(n, 2);
    $display("test internal rom done");
    end_of_test();
  end
  initial begin
    #60us;
    n_fail++;
    end_of_test();
  end
endmodule
